// ===== rtl/upr_regs.svh
// register map, field positions, reset values and sizes of the port routing block
`ifndef UPR_REGS_SVH
`define UPR_REGS_SVH
`define UPR_NUM_PORTS 10
`define UPR_ADDR_CONFIG 6'h00
`define UPR_ADDR_OWNER 6'h04
`define UPR_ADDR_DEBUG 6'h08
`define UPR_ADDR_STATUS 6'h0c
`define UPR_ADDR_CONNECT 6'h10
`define UPR_ADDR_ENABLE 6'h14
`define UPR_ADDR_ROUTE 6'h18
`define UPR_ADDR_ID 6'h1c
`define UPR_CFG_FLAG_BIT 0
`define UPR_DBG_OWNER_BIT 0
`define UPR_DBG_ENABLED_BIT 1
`define UPR_DBG_SLOT_BIT 2
`define UPR_DBG_BADSTS_BIT 3
`define UPR_DBG_PORT 0
// arbitrary identification value, names no maker or part
`define UPR_ID_VALUE 32'h0000a5c3
`define UPR_RST_CFG_FLAG 1'b0
`define UPR_RST_OWNER_BIT 1'b1
`endif

// ===== rtl/upr_pkg.sv
// types shared by the port routing block
package upr_pkg;
  typedef enum logic [1:0] {
    UPR_DBG_IDLE,
    UPR_DBG_ACTIVE,
    UPR_DBG_HELD
  } upr_dbg_state_e;
endpackage

// ===== rtl/upr_port_if.sv
// per-port owner and connect signals between the routing top and the port mux
`timescale 1ns/1ns
interface upr_port_if #(parameter int N = 10);
  logic [N-1:0] owner_comp;
  logic [N-1:0] phys_conn;
  logic [N-1:0] comp_conn;
  logic [N-1:0] enh_conn;
  modport ctrl (output owner_comp, output phys_conn, input comp_conn, input enh_conn);
  modport mux (input owner_comp, input phys_conn, output comp_conn, output enh_conn);
endinterface

// ===== rtl/upr_port_mux.sv
// differential-pair multiplexer and connect generator for all ports
`timescale 1ns/1ns
module upr_port_mux #(
  parameter int N = 10
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  upr_port_if.mux pif,
  input wire [N-1:0] comp_tx_dp_i,
  input wire [N-1:0] comp_tx_dm_i,
  input wire [N-1:0] comp_tx_oe_i,
  input wire [N-1:0] enh_tx_dp_i,
  input wire [N-1:0] enh_tx_dm_i,
  input wire [N-1:0] enh_tx_oe_i,
  input wire [N-1:0] rx_dp_i,
  input wire [N-1:0] rx_dm_i,
  output logic [N-1:0] port_dp_o,
  output logic [N-1:0] port_dm_o,
  output logic [N-1:0] port_oe_o,
  output logic [N-1:0] comp_rx_dp_o,
  output logic [N-1:0] comp_rx_dm_o,
  output logic [N-1:0] enh_rx_dp_o,
  output logic [N-1:0] enh_rx_dm_o
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_port
      wire own_c = pif.owner_comp[g];
      wire next_dp = own_c ? comp_tx_dp_i[g] : enh_tx_dp_i[g];
      wire next_dm = own_c ? comp_tx_dm_i[g] : enh_tx_dm_i[g];
      wire next_oe = own_c ? comp_tx_oe_i[g] : enh_tx_oe_i[g];
      // only the owner drives the pair, only the owner sees the stream
      // non-owner sees a disconnected port
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          port_dp_o[g] <= 1'b0;
          port_dm_o[g] <= 1'b0;
          port_oe_o[g] <= 1'b0;
          comp_rx_dp_o[g] <= 1'b0;
          comp_rx_dm_o[g] <= 1'b0;
          enh_rx_dp_o[g] <= 1'b0;
          enh_rx_dm_o[g] <= 1'b0;
          pif.comp_conn[g] <= 1'b0;
          pif.enh_conn[g] <= 1'b0;
        end else begin
          port_dp_o[g] <= next_dp;
          port_dm_o[g] <= next_dm;
          port_oe_o[g] <= next_oe;
          comp_rx_dp_o[g] <= own_c & rx_dp_i[g];
          comp_rx_dm_o[g] <= own_c & rx_dm_i[g];
          enh_rx_dp_o[g] <= ~own_c & rx_dp_i[g];
          enh_rx_dm_o[g] <= ~own_c & rx_dm_i[g];
          pif.comp_conn[g] <= own_c & pif.phys_conn[g];
          pif.enh_conn[g] <= ~own_c & pif.phys_conn[g];
        end
      end
    end
  endgenerate
endmodule // upr_port_mux

// ===== rtl/upr_port_routing.sv
// port ownership routing between companion and enhanced host controllers
//
// Summary of operation
// - companion owns full/low-speed or unconfigured ports
// - only owner drives pair and receives stream
// - non-owner sees a disconnected port
// - controllers see only generated connect status
// - only differential pairs pass the mux
// - overcurrent goes to both controllers always
// - routing state kept in suspend-well reset domain
// - debug active gives enhanced controller port 0
// - flag clear keeps companion owner on connect
// - flag set, slow device: enable clear, owner write
// - flag set, fast device: enhanced owns, enabled
// - slow device detach forces owner bit zero
// - fast device detach keeps enhanced owner
// - well or controller reset: flag 0, owners 1
// - core and D3-D0 resets leave routing alone
// - debug works before drivers and port disabled
// - debug buffer: one access per microframe
// - debug only in D0, unsuspended, not resetting
// - normal traffic may share the debug port
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ns
`include "upr_regs.svh"
module upr_port_routing #(
  parameter int N = `UPR_NUM_PORTS,
  parameter logic [31:0] ID_VALUE = `UPR_ID_VALUE
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire host_controller_soft_reset_i,
  input wire core_reset_i,
  input wire d3_to_d0_reset_i,
  input wire power_d0_i,
  input wire microframe_tick_i,
  input wire debug_req_i,
  input wire debug_bus_err_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire [N-1:0] phys_conn_i,
  input wire [N-1:0] dev_high_speed_i,
  input wire [N-1:0] port_reset_i,
  input wire [N-1:0] port_suspend_i,
  input wire [N-1:0] overcurrent_in_n_i,
  input wire [N-1:0] comp_tx_dp_i,
  input wire [N-1:0] comp_tx_dm_i,
  input wire [N-1:0] comp_tx_oe_i,
  input wire [N-1:0] enh_tx_dp_i,
  input wire [N-1:0] enh_tx_dm_i,
  input wire [N-1:0] enh_tx_oe_i,
  input wire [N-1:0] rx_dp_i,
  input wire [N-1:0] rx_dm_i,
  output logic [N-1:0] port_dp_o,
  output logic [N-1:0] port_dm_o,
  output logic [N-1:0] port_oe_o,
  output logic [N-1:0] comp_rx_dp_o,
  output logic [N-1:0] comp_rx_dm_o,
  output logic [N-1:0] enh_rx_dp_o,
  output logic [N-1:0] enh_rx_dm_o,
  output logic [N-1:0] comp_conn_o,
  output logic [N-1:0] enh_conn_o,
  output logic [N-1:0] enh_port_enable_o,
  output logic [N-1:0] comp_overcurrent_n_o,
  output logic [N-1:0] enh_overcurrent_n_o,
  output logic debug_grant_o,
  output logic debug_slot_o
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (N < 1 || N > 16) begin : g_bad_n
    $error("upr_port_routing: N must be 1..16");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [N-1:0] conn_s1, conn_s2, hs_s1, hs_s2, oc_s1, oc_s2;
  logic [N-1:0] prst_s1, prst_s2, susp_s1, susp_s2;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conn_s1 <= '0;
      conn_s2 <= '0;
      hs_s1 <= '0;
      hs_s2 <= '0;
      oc_s1 <= '1;
      oc_s2 <= '1;
      prst_s1 <= '0;
      prst_s2 <= '0;
      susp_s1 <= '0;
      susp_s2 <= '0;
    end else begin
      conn_s1 <= phys_conn_i;
      conn_s2 <= conn_s1;
      hs_s1 <= dev_high_speed_i;
      hs_s2 <= hs_s1;
      oc_s1 <= overcurrent_in_n_i;
      oc_s2 <= oc_s1;
      prst_s1 <= port_reset_i;
      prst_s2 <= prst_s1;
      susp_s1 <= port_suspend_i;
      susp_s2 <= susp_s1;
    end
  end

  // ----------------------------------------------------------------
  // received pair synchroniser
  // ----------------------------------------------------------------
  logic [N-1:0] rxp_s1, rxp_s2, rxm_s1, rxm_s2;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxp_s1 <= '0;
      rxp_s2 <= '0;
      rxm_s1 <= '0;
      rxm_s2 <= '0;
    end else begin
      rxp_s1 <= rx_dp_i;
      rxp_s2 <= rxp_s1;
      rxm_s1 <= rx_dm_i;
      rxm_s2 <= rxm_s1;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire [5:0] adr = wb_adr_i[5:0];
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands on the edge that sees ack high
  wire wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire sel_cfg = adr == `UPR_ADDR_CONFIG;
  wire sel_own = adr == `UPR_ADDR_OWNER;
  wire sel_dbg = adr == `UPR_ADDR_DEBUG;
  wire sel_sts = adr == `UPR_ADDR_STATUS;
  wire sel_con = adr == `UPR_ADDR_CONNECT;
  wire sel_ena = adr == `UPR_ADDR_ENABLE;
  wire sel_rte = adr == `UPR_ADDR_ROUTE;
  wire sel_id = adr == `UPR_ADDR_ID;
  wire wr_cfg = wr & sel_cfg;
  wire wr_own = wr & sel_own;
  wire wr_dbg = wr & sel_dbg;
  wire wr_sts = wr & sel_sts;

  // ----------------------------------------------------------------
  // routing state, reset only by suspend well or controller reset
  // ----------------------------------------------------------------
  logic cfg_flag;
  logic [N-1:0] owner;
  logic [N-1:0] conn_q;
  logic dbg_owner, dbg_enabled, dbg_bad;
  // core and d3-to-d0 resets do not reach this state
  wire unused_resets = core_reset_i | d3_to_d0_reset_i;
  wire [N-1:0] detach = conn_q & ~conn_s2;
  // full/low-speed detach hands the empty port back to enhanced
  wire [N-1:0] force_enh = {N{cfg_flag}} & detach & owner;
  wire [N-1:0] wr_owner_val = wb_dat_i[N-1:0];
  wire [N-1:0] next_owner = wr_own ? (wr_owner_val & ~force_enh) : (owner & ~force_enh);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_flag <= `UPR_RST_CFG_FLAG;
      owner <= {N{`UPR_RST_OWNER_BIT}};
      conn_q <= '0;
    end else if (host_controller_soft_reset_i) begin
      cfg_flag <= `UPR_RST_CFG_FLAG;
      owner <= {N{`UPR_RST_OWNER_BIT}};
      conn_q <= conn_s2;
    end else begin
      conn_q <= conn_s2;
      if (wr_cfg) begin
        cfg_flag <= wb_dat_i[`UPR_CFG_FLAG_BIT];
      end
      owner <= next_owner;
    end
  end

  // ----------------------------------------------------------------
  // ownership select
  // ----------------------------------------------------------------
  // debug routing active: enhanced owns the debug port
  wire dbg_route = dbg_owner & dbg_enabled;
  wire [N-1:0] dbg_mask = dbg_route ? (N'(1) << `UPR_DBG_PORT) : '0;
  // companion owns when flag clear or owner bit set
  wire [N-1:0] owner_comp = ({N{~cfg_flag}} | owner) & ~dbg_mask;

  upr_port_if #(.N(N)) pif ();
  assign pif.owner_comp = owner_comp;
  assign pif.phys_conn = conn_s2;

  upr_port_mux #(.N(N)) u_mux (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pif(pif),
    .comp_tx_dp_i(comp_tx_dp_i),
    .comp_tx_dm_i(comp_tx_dm_i),
    .comp_tx_oe_i(comp_tx_oe_i),
    .enh_tx_dp_i(enh_tx_dp_i),
    .enh_tx_dm_i(enh_tx_dm_i),
    .enh_tx_oe_i(enh_tx_oe_i),
    .rx_dp_i(rxp_s2),
    .rx_dm_i(rxm_s2),
    .port_dp_o(port_dp_o),
    .port_dm_o(port_dm_o),
    .port_oe_o(port_oe_o),
    .comp_rx_dp_o(comp_rx_dp_o),
    .comp_rx_dm_o(comp_rx_dm_o),
    .enh_rx_dp_o(enh_rx_dp_o),
    .enh_rx_dm_o(enh_rx_dm_o)
  );

  // ----------------------------------------------------------------
  // enhanced port enable output
  // ----------------------------------------------------------------
  logic [N-1:0] prst_q;
  wire [N-1:0] reset_done = prst_q & ~prst_s2;
  // enable only for high-speed device after reset on enhanced port
  wire [N-1:0] en_set = reset_done & hs_s2 & ~owner_comp & conn_s2;
  wire [N-1:0] en_clr = ~conn_s2 | owner_comp | prst_s2;
  wire [N-1:0] next_enable = (enh_port_enable_o | en_set) & ~en_clr;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prst_q <= '0;
      enh_port_enable_o <= '0;
    end else begin
      prst_q <= prst_s2;
      enh_port_enable_o <= next_enable;
    end
  end

  // ----------------------------------------------------------------
  // connect and overcurrent copies
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      comp_overcurrent_n_o <= '1;
      enh_overcurrent_n_o <= '1;
      comp_conn_o <= '0;
      enh_conn_o <= '0;
    end else begin
      comp_overcurrent_n_o <= oc_s2;
      enh_overcurrent_n_o <= oc_s2;
      comp_conn_o <= pif.comp_conn;
      enh_conn_o <= pif.enh_conn;
    end
  end

  // ----------------------------------------------------------------
  // debug port gating
  // ----------------------------------------------------------------
  upr_pkg::upr_dbg_state_e dbg_state, next_dbg_state;
  logic slot_used;
  // runs only in d0, port not suspended and not in bus reset
  wire dbg_ok = power_d0_i & ~susp_s2[`UPR_DBG_PORT] & ~prst_s2[`UPR_DBG_PORT];
  // one access per microframe; a grant in the tick cycle opens the new slot
  wire slot_free = ~slot_used | microframe_tick_i;
  wire grant = dbg_route & dbg_ok & debug_req_i & slot_free;

  always_comb begin
    next_dbg_state = dbg_state;
    case (dbg_state)
      upr_pkg::UPR_DBG_IDLE: begin
        if (grant) next_dbg_state = upr_pkg::UPR_DBG_ACTIVE;
        else if (dbg_route & ~dbg_ok) next_dbg_state = upr_pkg::UPR_DBG_HELD;
      end
      upr_pkg::UPR_DBG_ACTIVE: begin
        next_dbg_state = upr_pkg::UPR_DBG_IDLE;
      end
      upr_pkg::UPR_DBG_HELD: begin
        if (grant) next_dbg_state = upr_pkg::UPR_DBG_ACTIVE;
        else if (dbg_ok | ~dbg_route) next_dbg_state = upr_pkg::UPR_DBG_IDLE;
      end
      default: next_dbg_state = upr_pkg::UPR_DBG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbg_state <= upr_pkg::UPR_DBG_IDLE;
      slot_used <= 1'b0;
      debug_grant_o <= 1'b0;
      debug_slot_o <= 1'b0;
    end else begin
      dbg_state <= next_dbg_state;
      slot_used <= grant | (slot_used & ~microframe_tick_i);
      debug_grant_o <= grant;
      debug_slot_o <= slot_used | grant;
    end
  end

  // bad status is flagged to software, never retried; set wins
  wire bad_set = debug_bus_err_i & (dbg_state == upr_pkg::UPR_DBG_ACTIVE);
  wire bad_clr = wr_sts & wb_dat_i[`UPR_DBG_BADSTS_BIT];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbg_owner <= 1'b0;
      dbg_enabled <= 1'b0;
    end else if (wr_dbg) begin
      dbg_owner <= wb_dat_i[`UPR_DBG_OWNER_BIT];
      dbg_enabled <= wb_dat_i[`UPR_DBG_ENABLED_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbg_bad <= 1'b0;
    end else begin
      dbg_bad <= bad_set | (dbg_bad & ~bad_clr);
    end
  end

  // ----------------------------------------------------------------
  // bus read mux and ack
  // ----------------------------------------------------------------
  wire [31:0] rd_cfg = {31'h0, cfg_flag};
  wire [31:0] rd_own = 32'(owner);
  wire [31:0] rd_dbg = {30'h0, dbg_enabled, dbg_owner};
  wire [31:0] rd_sts = {28'h0, dbg_bad, slot_used, dbg_enabled & dbg_ok, unused_resets};
  wire [31:0] rd_con = 32'(conn_s2);
  wire [31:0] rd_ena = 32'(enh_port_enable_o);
  wire [31:0] rd_rte = 32'(owner_comp);
  wire [31:0] rd_data = sel_cfg ? rd_cfg :
                        sel_own ? rd_own :
                        sel_dbg ? rd_dbg :
                        sel_sts ? rd_sts :
                        sel_con ? rd_con :
                        sel_ena ? rd_ena :
                        sel_rte ? rd_rte :
                        sel_id ? ID_VALUE : 32'h0;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_data : 32'h0;
    end
  end
endmodule // upr_port_routing

// ===== test/upr_port_routing_properties.sv
// concurrent checks on the ports of the port routing top
`timescale 1ns/1ns
module upr_port_routing_props #(
  parameter int N = 10
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire host_controller_soft_reset_i,
  input wire power_d0_i,
  input wire microframe_tick_i,
  input wire [N-1:0] phys_conn_i,
  input wire [N-1:0] comp_tx_oe_i,
  input wire [N-1:0] enh_tx_oe_i,
  input wire [N-1:0] rx_dp_i,
  input logic [N-1:0] port_oe_o,
  input logic [N-1:0] comp_rx_dp_o,
  input logic [N-1:0] enh_rx_dp_o,
  input logic [N-1:0] comp_conn_o,
  input logic [N-1:0] enh_conn_o,
  input logic [N-1:0] comp_overcurrent_n_o,
  input logic [N-1:0] enh_overcurrent_n_o,
  input logic debug_grant_o
);
  logic granted;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ------------------------------------------------------------
  // grant seen since the last microframe start
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      granted <= 1'b0;
    end else begin
      granted <= microframe_tick_i ? 1'b0 : (granted | debug_grant_o);
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  ovc_both_a: assert property (comp_overcurrent_n_o == enh_overcurrent_n_o)
    else $error("overcurrent copies differ");
  one_owner_a: assert property ((comp_conn_o & enh_conn_o) == '0)
    else $error("port connected at both controllers");
  rx_to_one_a: assert property ((comp_rx_dp_o & enh_rx_dp_o) == '0)
    else $error("received stream given to both controllers");
  rx_source_a: assert property (((comp_rx_dp_o | enh_rx_dp_o) & ~$past(rx_dp_i, 3)) == '0)
    else $error("received stream not from the pin");
  oe_source_a: assert property ((port_oe_o & ~$past(comp_tx_oe_i | enh_tx_oe_i)) == '0)
    else $error("pin driven without a controller enable");
  no_phantom_a: assert property ((phys_conn_i == '0) [*6] |=>
    (comp_conn_o | enh_conn_o) == '0) else $error("connect shown with nothing attached");
  hc_reset_a: assert property (host_controller_soft_reset_i [*3] |=>
    (enh_conn_o >> 1) == '0) else $error("enhanced side still owns after reset");
  one_slot_a: assert property (debug_grant_o |-> !granted)
    else $error("second debug slot in one microframe");
  d0_gate_a: assert property ((!power_d0_i) [*3] |=> !debug_grant_o)
    else $error("debug slot granted outside D0");
endmodule // upr_port_routing_props

bind upr_port_routing upr_port_routing_props #(.N(N)) upr_port_routing_props_i (
  .ref_clk_i, .rst_n_i, .host_controller_soft_reset_i, .power_d0_i, .microframe_tick_i,
  .phys_conn_i, .comp_tx_oe_i, .enh_tx_oe_i, .rx_dp_i, .port_oe_o, .comp_rx_dp_o,
  .enh_rx_dp_o, .comp_conn_o, .enh_conn_o, .comp_overcurrent_n_o, .enh_overcurrent_n_o,
  .debug_grant_o);

// ===== test/upr_dev_model.sv
// behavioural usb devices at the root ports
`timescale 1ns/1ns
module upr_dev_model #(
  parameter int N = 10
) (
  input wire [N-1:0] attach_i,
  input wire [N-1:0] fast_i,
  output logic [N-1:0] phys_conn_o,
  output logic [N-1:0] high_speed_o,
  output logic [N-1:0] rx_dp_o,
  output logic [N-1:0] rx_dm_o
);
  // detached lines fall to the host pull-downs; attached devices idle in j state
  assign phys_conn_o = attach_i;
  assign high_speed_o = attach_i & fast_i;
  assign rx_dp_o = attach_i;
  assign rx_dm_o = '0;
endmodule // upr_dev_model

// ===== test/tb_upr_port_routing.sv
// self-checking bench for the port routing block
`timescale 1ns/1ns
`include "upr_regs.svh"
module tb_upr_port_routing;
  localparam int NP = 2;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, host_controller_soft_reset_i = 1'b0;
  logic core_reset_i = 1'b0, d3_to_d0_reset_i = 1'b0, power_d0_i = 1'b1;
  logic microframe_tick_i = 1'b0, debug_req_i = 1'b0, debug_bus_err_i = 1'b0;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, debug_grant_o, debug_slot_o;
  logic [NP-1:0] attach = '0, fast = '0, port_reset_i = '0, port_suspend_i = '0;
  logic [NP-1:0] overcurrent_in_n_i = '1, comp_tx_dp_i = '0, comp_tx_dm_i = '0, comp_tx_oe_i = '0;
  logic [NP-1:0] enh_tx_dp_i = '0, enh_tx_dm_i = '0, enh_tx_oe_i = '0;
  logic [NP-1:0] phys_conn_i, dev_high_speed_i, rx_dp_i, rx_dm_i, port_dp_o, port_dm_o;
  logic [NP-1:0] port_oe_o, comp_rx_dp_o, comp_rx_dm_o, enh_rx_dp_o, enh_rx_dm_o;
  logic [NP-1:0] comp_conn_o, enh_conn_o, enh_port_enable_o, comp_overcurrent_n_o;
  logic [NP-1:0] enh_overcurrent_n_o;
  int n_errors = 0, cmp_count = 0, grants = 0;
  upr_port_routing #(.N(NP)) upr_port_routing_i (
    .ref_clk_i, .rst_n_i, .host_controller_soft_reset_i, .core_reset_i, .d3_to_d0_reset_i,
    .power_d0_i, .microframe_tick_i, .debug_req_i, .debug_bus_err_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .phys_conn_i,
    .dev_high_speed_i, .port_reset_i, .port_suspend_i, .overcurrent_in_n_i, .comp_tx_dp_i,
    .comp_tx_dm_i, .comp_tx_oe_i, .enh_tx_dp_i, .enh_tx_dm_i, .enh_tx_oe_i, .rx_dp_i,
    .rx_dm_i, .port_dp_o, .port_dm_o, .port_oe_o, .comp_rx_dp_o, .comp_rx_dm_o,
    .enh_rx_dp_o, .enh_rx_dm_o, .comp_conn_o, .enh_conn_o, .enh_port_enable_o,
    .comp_overcurrent_n_o, .enh_overcurrent_n_o, .debug_grant_o, .debug_slot_o);
  upr_dev_model #(.N(NP)) upr_dev_model_i (.attach_i(attach), .fast_i(fast),
    .phys_conn_o(phys_conn_i), .high_speed_o(dev_high_speed_i), .rx_dp_o(rx_dp_i),
    .rx_dm_o(rx_dm_i));
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (debug_grant_o === 1'b1) grants++;
  end
  // ------------------------------------------------------------
  // bus cycles and compares
  // ------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic bus(input logic [31:0] adr, input logic we, input logic [31:0] dat);
    int t;
    t = 0;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    do begin
      @(posedge ref_clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) n_errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkp(input logic [NP-1:0] got, input logic [NP-1:0] exp);
    chk(32'(got), 32'(exp));
  endtask
  task automatic rdc(input logic [31:0] adr, input logic [31:0] exp);
    bus(adr, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic prst(input logic [NP-1:0] p);
    port_reset_i <= p;
    wt(6);
    port_reset_i <= '0;
    wt(8);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      microframe_tick_i <= 1'b1;
      wt(1);
      microframe_tick_i <= 1'b0;
      wt(20);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    wt(20000);
    n_errors++;
    conclude();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    wt(8);
    rst_n_i <= 1'b1;
    rdc(`UPR_ADDR_CONFIG, 32'h0);
    rdc(`UPR_ADDR_OWNER, 32'h3);
    rdc(`UPR_ADDR_ID, `UPR_ID_VALUE);
    bus(32'h20, 1'b1, 32'hffff_ffff);
    rdc(32'h20, 32'h0);
    $display("test reset done");
    attach <= 2'b10;
    fast <= 2'b10;
    comp_tx_dp_i <= 2'b10;
    comp_tx_oe_i <= 2'b10;
    comp_tx_dm_i <= 2'b01;
    enh_tx_oe_i <= 2'b01;
    overcurrent_in_n_i <= 2'b01;
    wt(8);
    chkp(comp_conn_o, 2'b10);
    chkp(enh_conn_o, 2'b00);
    chkp(port_oe_o, 2'b10);
    chkp(port_dp_o, 2'b10);
    chkp(port_dm_o, 2'b01);
    chkp(comp_rx_dp_o, 2'b10);
    chkp(enh_rx_dp_o, 2'b00);
    chkp(comp_overcurrent_n_o, 2'b01);
    chkp(enh_overcurrent_n_o, 2'b01);
    rdc(`UPR_ADDR_CONNECT, 32'h2);
    rdc(`UPR_ADDR_ROUTE, 32'h3);
    $display("test unconfigured done");
    bus(`UPR_ADDR_CONFIG, 1'b1, 32'h1);
    bus(`UPR_ADDR_OWNER, 1'b1, 32'h0);
    wt(8);
    chkp(enh_conn_o, 2'b10);
    prst(2'b10);
    chkp(enh_port_enable_o, 2'b10);
    chkp(comp_conn_o, 2'b00);
    attach <= 2'b00;
    wt(8);
    chkp(comp_conn_o, 2'b00);
    rdc(`UPR_ADDR_OWNER, 32'h0);
    $display("test fast device done");
    fast <= 2'b00;
    attach <= 2'b10;
    wt(8);
    chkp(enh_conn_o, 2'b10);
    prst(2'b10);
    chkp(enh_port_enable_o, 2'b00);
    bus(`UPR_ADDR_OWNER, 1'b1, 32'h2);
    wt(8);
    chkp(comp_conn_o, 2'b10);
    chkp(enh_conn_o, 2'b00);
    attach <= 2'b00;
    wt(8);
    rdc(`UPR_ADDR_OWNER, 32'h0);
    $display("test slow device done");
    bus(`UPR_ADDR_OWNER, 1'b1, 32'h1);
    core_reset_i <= 1'b1;
    d3_to_d0_reset_i <= 1'b1;
    wt(4);
    core_reset_i <= 1'b0;
    d3_to_d0_reset_i <= 1'b0;
    rdc(`UPR_ADDR_CONFIG, 32'h1);
    rdc(`UPR_ADDR_OWNER, 32'h1);
    attach <= 2'b10;
    wt(8);
    chkp(enh_conn_o, 2'b10);
    host_controller_soft_reset_i <= 1'b1;
    wt(4);
    host_controller_soft_reset_i <= 1'b0;
    rdc(`UPR_ADDR_CONFIG, 32'h0);
    rdc(`UPR_ADDR_OWNER, 32'h3);
    chkp(comp_conn_o, 2'b10);
    $display("test resets done");
    attach <= 2'b01;
    fast <= 2'b01;
    bus(`UPR_ADDR_DEBUG, 1'b1, 32'h3);
    wt(8);
    chkp(enh_conn_o, 2'b01);
    chkp(comp_conn_o, 2'b00);
    enh_tx_dp_i <= 2'b01;
    wt(3);
    chkp(port_dp_o, 2'b11);
    debug_req_i <= 1'b1;
    grants = 0;
    frames(2);
    chk(32'(grants), 32'h2);
    chk(32'(debug_slot_o), 32'h1);
    power_d0_i <= 1'b0;
    wt(4);
    grants = 0;
    frames(2);
    chk(32'(grants), 32'h0);
    power_d0_i <= 1'b1;
    port_suspend_i <= 2'b01;
    wt(4);
    grants = 0;
    frames(2);
    chk(32'(grants), 32'h0);
    port_suspend_i <= 2'b00;
    wt(4);
    microframe_tick_i <= 1'b1;
    wt(1);
    microframe_tick_i <= 1'b0;
    debug_req_i <= 1'b0;
    debug_bus_err_i <= 1'b1;
    wt(1);
    debug_bus_err_i <= 1'b0;
    wt(2);
    bus(`UPR_ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h8, 32'h8);
    bus(`UPR_ADDR_STATUS, 1'b1, 32'h8);
    bus(`UPR_ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h8, 32'h0);
    $display("test debug done");
    conclude();
  end
endmodule // tb_upr_port_routing
